// *** rtl/dma_pkg.sv ***
// constants, register map and field layout of the dma channel
package dma_pkg;
    localparam int WB_ADR_W = 8;
    localparam int WB_DAT_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PARAMS = 8'h04;
    localparam logic [7:0] OFS_ELEM = 8'h08;
    localparam logic [7:0] OFS_FRAME = 8'h0c;
    localparam logic [7:0] OFS_SRC = 8'h10;
    localparam logic [7:0] OFS_DEST = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_MASK = 8'h1c;
    // control register fields
    localparam int CTRL_W = 11;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_SYNC_LOW_LSB = 1;
    localparam int SYNC_LOW_W = 5;
    localparam int CTRL_SYNC_HIGH_LSB = 6;
    localparam int SYNC_HIGH_W = 2;
    localparam int CTRL_SIDE = 8;
    localparam int CTRL_PREFETCH = 9;
    localparam int CTRL_CHAIN = 10;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
    localparam logic SIDE_DEST = 1'b0;
    localparam logic PREFETCH_ON = 1'b1;
    // transfer parameter fields
    localparam int PARAMS_W = 6;
    localparam int P_PACK = 0;
    localparam int P_BURST = 1;
    localparam int P_ORDER = 2;
    localparam int P_AMODE_LSB = 3;
    localparam int AMODE_W = 2;
    localparam int P_COLOR_KEY = 5;
    localparam logic [PARAMS_W-1:0] PARAMS_RESET = 6'h00;
    localparam logic [AMODE_W-1:0] AMODE_POST_INC = 2'h1;
    // status and mask bits
    localparam int STATUS_W = 4;
    localparam int ST_DONE = 0;
    localparam int ST_MISALIGN = 1;
    localparam int ST_WR_ERR = 2;
    localparam int ST_RD_ERR = 3;
    localparam int ELEM_W = 24;
    localparam int FRAME_W = 16;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
endpackage

// *** rtl/gather_if.sv ***
// carrier between the channel and its gather buffer
`timescale 1ns/1ps
interface gather_if #(parameter int WIDTH = 32, parameter int CNT_W = 3);
    logic push;
    logic pop;
    logic flush;
    logic [WIDTH-1:0] push_data;
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] second;
    logic [CNT_W-1:0] count;
    modport buffer (input push, pop, flush, push_data, output head, second, count);
    modport user (output push, pop, flush, push_data, input head, second, count);
endinterface

// *** rtl/gather_buffer.sv ***
// gather buffer holding read data until the write port takes it
`timescale 1ns/1ps
module gather_buffer #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    parameter int CNT_W = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    gather_if.buffer gb
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [CNT_W-1:0] count_r;
    wire do_push = gb.push && (32'(count_r) < DEPTH || gb.pop);
    wire do_pop = gb.pop && count_r != '0;

    function automatic logic [PTR_W-1:0] inc(input logic [PTR_W-1:0] p);
        inc = (32'(p) == DEPTH - 1) ? '0 : p + 1'b1;
    endfunction

    assign gb.head = mem[rd_ptr_r];
    assign gb.second = mem[inc(rd_ptr_r)];
    assign gb.count = count_r;

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= gb.push_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (gb.flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_push) wr_ptr_r <= inc(wr_ptr_r);
            if (do_pop) rd_ptr_r <= inc(rd_ptr_r);
            count_r <= count_r + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end
endmodule // gather_buffer

// *** rtl/dma_channel.sv ***
// one dma channel with wishbone registers, read port and write port
//
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module dma_channel #(
    parameter int BURST_LEN = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dma_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [dma_pkg::WB_DAT_W-1:0] wb_dat_i,
    output logic [dma_pkg::WB_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic rd_req,
    output logic [31:0] rd_addr,
    input wire logic rd_ack,
    input wire logic [31:0] rd_data,
    input wire logic rd_err,
    output logic wr_req,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_be,
    output logic [$clog2(BURST_LEN+1)-1:0] wr_len,
    input wire logic wr_ack,
    input wire logic wr_err,
    input wire logic peripheral_request,
    input wire logic link_in,
    output logic link_out,
    output logic irq
);
    localparam int LEN_W = $clog2(BURST_LEN + 1);
    localparam int CNT_W = dma_pkg::ELEM_W + dma_pkg::FRAME_W;
    localparam logic [LEN_W-1:0] ONE_BEAT = LEN_W'(1);
    localparam logic [LEN_W-1:0] FULL_BURST = LEN_W'(BURST_LEN);

    typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_ABORT} ch_state_type;

    ch_state_type state_r;
    ch_state_type state_nxt;
    logic [dma_pkg::CTRL_W-1:0] ctrl_r;
    logic [dma_pkg::PARAMS_W-1:0] params_r;
    logic [dma_pkg::ELEM_W-1:0] elem_r;
    logic [dma_pkg::FRAME_W-1:0] frame_r;
    logic [31:0] src_r;
    logic [31:0] dest_r;
    logic [dma_pkg::STATUS_W-1:0] status_r;
    logic [dma_pkg::STATUS_W-1:0] status_nxt;
    logic [dma_pkg::STATUS_W-1:0] mask_r;
    logic [CNT_W-1:0] rd_left_r;
    logic [CNT_W-1:0] wr_left_r;
    logic req_pend_r;

    gather_if #(.WIDTH(32), .CNT_W(LEN_W)) gb ();

    gather_buffer #(.WIDTH(32), .DEPTH(BURST_LEN), .CNT_W(LEN_W)) u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .gb(gb)
    );

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            old[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
        merge = old;
    endfunction

    function automatic logic [31:0] order(input logic [31:0] d, input logic swap);
        order = swap ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction

    // register bus decode
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_req && wb_we_i;
    wire hit_ctrl = wb_adr_i == dma_pkg::OFS_CTRL;
    wire hit_status = wb_adr_i == dma_pkg::OFS_STATUS;
    wire [31:0] ctrl_rd = {{(32-dma_pkg::CTRL_W){1'b0}}, ctrl_r} |
                          32'(state_r != CH_IDLE);
    wire [31:0] ctrl_wr = merge(ctrl_rd, wb_dat_i, wb_sel_i);
    wire [31:0] params_wr = merge(32'(params_r), wb_dat_i, wb_sel_i);
    wire [31:0] elem_wr = merge(32'(elem_r), wb_dat_i, wb_sel_i);
    wire [31:0] frame_wr = merge(32'(frame_r), wb_dat_i, wb_sel_i);
    wire [31:0] src_wr = merge(src_r, wb_dat_i, wb_sel_i);
    wire [31:0] dest_wr = merge(dest_r, wb_dat_i, wb_sel_i);
    wire [31:0] mask_wr = merge(32'(mask_r), wb_dat_i, wb_sel_i);
    wire [31:0] clr_wr = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    logic [31:0] rd_mux;
    always_comb begin
        unique case (wb_adr_i)
            dma_pkg::OFS_CTRL: rd_mux = ctrl_rd;
            dma_pkg::OFS_PARAMS: rd_mux = 32'(params_r);
            dma_pkg::OFS_ELEM: rd_mux = 32'(elem_r);
            dma_pkg::OFS_FRAME: rd_mux = 32'(frame_r);
            dma_pkg::OFS_SRC: rd_mux = src_r;
            dma_pkg::OFS_DEST: rd_mux = dest_r;
            dma_pkg::OFS_STATUS: rd_mux = 32'(status_r);
            dma_pkg::OFS_MASK: rd_mux = 32'(mask_r);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // mode decode
    // no sync line selected: software paced
    function automatic logic no_sync(input logic [dma_pkg::CTRL_W-1:0] c);
        no_sync = c[dma_pkg::CTRL_SYNC_LOW_LSB +: dma_pkg::SYNC_LOW_W] == '0 &&
                  c[dma_pkg::CTRL_SYNC_HIGH_LSB +: dma_pkg::SYNC_HIGH_W] == '0;
    endfunction
    wire sw_sync = no_sync(ctrl_r);
    wire dest_prefetch = ctrl_r[dma_pkg::CTRL_SIDE] == dma_pkg::SIDE_DEST && !sw_sync &&
                         ctrl_r[dma_pkg::CTRL_PREFETCH] == dma_pkg::PREFETCH_ON;
    wire burst_mode = params_r[dma_pkg::P_BURST] && params_r[dma_pkg::P_PACK];
    wire post_inc = params_r[dma_pkg::P_AMODE_LSB +: dma_pkg::AMODE_W] ==
                    dma_pkg::AMODE_POST_INC;
    wire swap = params_r[dma_pkg::P_ORDER];

    // start, stop and abort
    wire idle = state_r == CH_IDLE;
    wire run = state_r == CH_RUN;
    wire start_sw = wb_wr && hit_ctrl && ctrl_wr[dma_pkg::CTRL_ENABLE] && idle;
    wire start_link = link_in && ctrl_r[dma_pkg::CTRL_CHAIN] && idle;
    wire start = start_sw || start_link;
    // a software start judges the sync fields it writes
    wire [dma_pkg::CTRL_W-1:0] ctrl_start = start_sw ? ctrl_wr[dma_pkg::CTRL_W-1:0] : ctrl_r;
    wire zero_frames = no_sync(ctrl_start) && frame_r == '0;
    wire stop_sw = wb_wr && hit_ctrl && !ctrl_wr[dma_pkg::CTRL_ENABLE] && run;
    wire wr_fault = run && wr_req && wr_err;
    wire rd_fault = run && rd_req && rd_err;
    wire abort = wr_fault || rd_fault || stop_sw;

    // read side
    wire rd_take = run && rd_req && rd_ack && !abort;
    wire rd_gate = sw_sync || dest_prefetch || req_pend_r;
    wire rd_go = run && !rd_req && rd_left_r != '0 && 32'(gb.count) < BURST_LEN &&
                 rd_gate && !abort;

    // write side
    wire [CNT_W-1:0] held = CNT_W'(gb.count);
    wire burst_ready = gb.count >= FULL_BURST || held == wr_left_r;
    wire fill_ok = burst_mode ? burst_ready : 1'b1;
    wire wr_gate = dest_prefetch ? req_pend_r : 1'b1;
    wire wr_go = run && !wr_req && gb.count != '0 && fill_ok && wr_gate && !abort;
    wire [LEN_W-1:0] beats = !burst_mode ? ONE_BEAT :
                             (gb.count >= FULL_BURST) ? FULL_BURST : gb.count;
    wire wr_take = run && wr_req && wr_ack && !wr_err && !stop_sw;
    wire last_beat = wr_take && wr_len == ONE_BEAT;
    wire block_done = wr_take && wr_left_r == CNT_W'(1);
    wire req_use = dest_prefetch ? wr_go : (!sw_sync && rd_go);

    assign gb.push = rd_take;
    assign gb.push_data = rd_data;
    assign gb.pop = wr_take;
    assign gb.flush = state_r == CH_ABORT;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CH_IDLE: if (start && !zero_frames) state_nxt = CH_RUN;
            CH_RUN: begin
                if (abort) state_nxt = CH_ABORT;
                else if (block_done) state_nxt = CH_IDLE;
            end
            CH_ABORT: state_nxt = CH_IDLE;
        endcase
    end

    always_comb begin
        status_nxt = status_r;
        if (wb_wr && hit_status) status_nxt = status_r & ~clr_wr[dma_pkg::STATUS_W-1:0];
        if (block_done) status_nxt[dma_pkg::ST_DONE] = 1'b1;
        if (start && zero_frames) status_nxt[dma_pkg::ST_MISALIGN] = 1'b1;
        if (wr_fault) status_nxt[dma_pkg::ST_WR_ERR] = 1'b1;
        if (rd_fault) status_nxt[dma_pkg::ST_RD_ERR] = 1'b1;
    end

    // register bus
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_mux : '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= dma_pkg::CTRL_RESET;
            params_r <= dma_pkg::PARAMS_RESET;
            elem_r <= '0;
            frame_r <= '0;
            src_r <= '0;
            dest_r <= '0;
            mask_r <= '0;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                dma_pkg::OFS_CTRL: ctrl_r <= ctrl_wr[dma_pkg::CTRL_W-1:0] &
                                            ~dma_pkg::CTRL_W'(1);
                dma_pkg::OFS_PARAMS: params_r <= params_wr[dma_pkg::PARAMS_W-1:0];
                dma_pkg::OFS_ELEM: elem_r <= elem_wr[dma_pkg::ELEM_W-1:0];
                dma_pkg::OFS_FRAME: frame_r <= frame_wr[dma_pkg::FRAME_W-1:0];
                dma_pkg::OFS_SRC: src_r <= src_wr;
                dma_pkg::OFS_DEST: dest_r <= dest_wr;
                dma_pkg::OFS_MASK: mask_r <= mask_wr[dma_pkg::STATUS_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CH_IDLE;
            status_r <= '0;
            irq <= 1'b0;
            link_out <= 1'b0;
            req_pend_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            status_r <= status_nxt;
            irq <= |(status_nxt & mask_r);
            link_out <= block_done;
            // request seen while held wins over its use
            req_pend_r <= run && (peripheral_request || (req_pend_r && !req_use));
        end
    end

    // read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_req <= 1'b0;
            rd_addr <= '0;
            rd_left_r <= '0;
        end else if (start && !zero_frames) begin
            rd_addr <= src_r;
            rd_left_r <= CNT_W'(elem_r) * CNT_W'(frame_r);
        end else if (abort || !run) begin
            rd_req <= 1'b0;
        end else if (rd_go) begin
            rd_req <= 1'b1;
        end else if (rd_take) begin
            rd_req <= 1'b0;
            rd_addr <= rd_addr + dma_pkg::WORD_STEP;
            rd_left_r <= rd_left_r - CNT_W'(1);
        end
    end

    // write port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_req <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_be <= '0;
            wr_len <= '0;
            wr_left_r <= '0;
        end else if (start && !zero_frames) begin
            wr_addr <= dest_r;
            wr_left_r <= CNT_W'(elem_r) * CNT_W'(frame_r);
        end else if (abort || !run) begin
            wr_req <= 1'b0;
            wr_be <= '0;
            wr_len <= '0;
        end else if (wr_go) begin
            wr_req <= 1'b1;
            wr_be <= 4'hf;
            wr_len <= beats;
            wr_data <= order(gb.head, swap);
        end else if (wr_take) begin
            wr_left_r <= wr_left_r - CNT_W'(1);
            wr_len <= wr_len - ONE_BEAT;
            wr_data <= order(gb.second, swap);
            if (post_inc) wr_addr <= wr_addr + dma_pkg::WORD_STEP;
            if (last_beat) begin
                wr_req <= 1'b0;
                wr_be <= '0;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_zero_frame_start;
        start && zero_frames |=> idle && status_r[dma_pkg::ST_MISALIGN] && !rd_req [*3];
    endproperty
    a_zero_frame_start: assert property (p_zero_frame_start) else $error("zero frame start");

    property p_swsync_decode;
        run && sw_sync && !rd_req && rd_left_r != '0 && gb.count == '0 && !abort |=> rd_req;
    endproperty
    a_swsync_decode: assert property (p_swsync_decode) else $error("sw sync read stall");

    property p_prefetch_waits;
        $rose(wr_req) && dest_prefetch |-> $past(req_pend_r) && $past(gb.count) != '0;
    endproperty
    a_prefetch_waits: assert property (p_prefetch_waits) else $error("write w/o request");

    property p_never_empty_write;
        wr_req |-> wr_be == 4'hf && wr_len != '0;
    endproperty
    a_never_empty_write: assert property (p_never_empty_write) else $error("empty write");

    property p_wr_error_abort;
        wr_fault |=> !wr_req && !rd_req && state_r == CH_ABORT ##1 idle && gb.count == '0;
    endproperty
    a_wr_error_abort: assert property (p_wr_error_abort) else $error("no clean abort");

    property p_wr_error_flag;
        wr_fault |=> status_r[dma_pkg::ST_WR_ERR] ##1 irq == mask_r[dma_pkg::ST_WR_ERR];
    endproperty
    a_wr_error_flag: assert property (p_wr_error_flag) else $error("error flag lost");

    property p_link_start;
        start_link && !zero_frames |=> run ##1 (rd_req || !rd_gate || rd_left_r == '0);
    endproperty
    a_link_start: assert property (p_link_start) else $error("link did not start");

    property p_burst_len;
        $rose(wr_req) && burst_mode |-> wr_len == FULL_BURST || CNT_W'(wr_len) == wr_left_r;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("short burst");

    property p_single_len;
        $rose(wr_req) && !burst_mode |-> wr_len == ONE_BEAT;
    endproperty
    a_single_len: assert property (p_single_len) else $error("single length");

    property p_done_link;
        block_done && !abort |=> link_out && idle && status_r[dma_pkg::ST_DONE];
    endproperty
    a_done_link: assert property (p_done_link) else $error("no link at block end");

    property p_sw_start;
        start_sw && !zero_frames |=> run;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("enable write ignored");

    c_block_done: cover property (block_done);
    c_burst_write: cover property ($rose(wr_req) && wr_len == FULL_BURST);
    c_abort_then_link: cover property (wr_fault ##[1:200] start_link);
    c_zero_frame: cover property (start && zero_frames);
endmodule // dma_channel

// *** sim/bus_target_model.sv ***
// read and write targets on the interconnect side of the dma channel
`timescale 1ns/1ps
module bus_target_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_req,
    input wire logic [31:0] rd_addr,
    output logic rd_ack,
    output logic [31:0] rd_data,
    input wire logic wr_req,
    input wire logic [31:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [3:0] wr_be,
    input wire logic [2:0] wr_len,
    output logic wr_ack,
    output logic wr_err,
    input wire logic [3:0] rd_delay,
    input wire logic err_arm,
    output int reads,
    output int beats,
    output int bursts,
    output int bad_be,
    output logic [31:0] last_addr,
    output logic [31:0] last_data
);
    logic [3:0] wait_r;
    logic wr_req_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ack <= 1'b0;
            rd_data <= 32'h0;
            wait_r <= 4'h0;
            wr_ack <= 1'b0;
            wr_err <= 1'b0;
            wr_req_d <= 1'b0;
            reads <= 0;
            beats <= 0;
            bursts <= 0;
            bad_be <= 0;
            last_addr <= 32'h0;
            last_data <= 32'h0;
        end else begin
            rd_ack <= 1'b0;
            // data outside an answer keeps changing
            rd_data <= ~rd_data;
            if (rd_req && !rd_ack) begin
                if (wait_r == rd_delay) begin
                    rd_ack <= 1'b1;
                    rd_data <= rd_addr ^ 32'h5a5a0000;
                    wait_r <= 4'h0;
                    reads <= reads + 1;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end
            wr_ack <= 1'b0;
            wr_err <= 1'b0;
            wr_req_d <= wr_req;
            if (wr_req && !wr_req_d && wr_len == 3'h4) begin
                bursts <= bursts + 1;
            end
            if (wr_req && wr_be !== 4'hf) begin
                bad_be <= bad_be + 1;
            end
            if (wr_req && !wr_ack && !wr_err) begin
                if (err_arm) begin
                    wr_err <= 1'b1;
                end else begin
                    wr_ack <= 1'b1;
                end
            end
            if (wr_req && wr_ack) begin
                beats <= beats + 1;
                last_addr <= wr_addr;
                last_data <= wr_data;
            end
        end
    end
endmodule // bus_target_model

// *** sim/test_dma_channel_abort_chain_recovery.sv ***
// self-checking bench for the dma channel
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module test_dma_channel_abort_chain_recovery;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, wb_dat_o, rd_addr, rd_data, wr_addr, wr_data, last_addr, last_data;
    logic wb_ack_o, rd_req, rd_ack, wr_req, wr_ack, wr_err, link_out, irq;
    logic [3:0] wr_be;
    logic [2:0] wr_len;
    logic peripheral_request = 1'b0, link_in = 1'b0, err_arm = 1'b0;
    logic [3:0] rd_delay = 4'h1;
    logic [31:0] q;
    int failures = 0, n_checks = 0, reads, beats, bursts, bad_be, b0, w0, r0;

    dma_channel #(.BURST_LEN(4)) dma_channel_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_ack(rd_ack), .rd_data(rd_data), .rd_err(1'b0), .wr_req(wr_req), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_be(wr_be), .wr_len(wr_len), .wr_ack(wr_ack), .wr_err(wr_err),
        .peripheral_request(peripheral_request), .link_in(link_in), .link_out(link_out),
        .irq(irq));
    bus_target_model bus_target_model_i (.clk(clk), .rst_n(rst_n), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be), .wr_len(wr_len), .wr_ack(wr_ack),
        .wr_err(wr_err), .rd_delay(rd_delay), .err_arm(err_arm), .reads(reads), .beats(beats),
        .bursts(bursts), .bad_be(bad_be), .last_addr(last_addr), .last_data(last_data));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_irq;
        for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
    endtask

    task automatic setup(input logic [31:0] elem, input logic [31:0] frame);
        wb(1'b1, dma_pkg::OFS_ELEM, elem);
        wb(1'b1, dma_pkg::OFS_FRAME, frame);
        // pack, burst, post increment
        wb(1'b1, dma_pkg::OFS_PARAMS, 32'h0000000b);
        wb(1'b1, dma_pkg::OFS_SRC, 32'h00000100);
        wb(1'b1, dma_pkg::OFS_DEST, 32'habcd0000);
        b0 = bursts;
        w0 = beats;
        r0 = reads;
    endtask

    task automatic t_reset_values;
        wb(1'b0, dma_pkg::OFS_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h0, q)
        wb(1'b0, dma_pkg::OFS_STATUS, 32'h0);
        `CHK("status reset", 32'h0, q)
        wb(1'b1, 8'h40, 32'hffffffff);
        wb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, q)
    endtask

    task automatic t_sw_burst;
        setup(32'h8, 32'h1);
        wb(1'b1, dma_pkg::OFS_MASK, 32'h1);
        wb(1'b1, dma_pkg::OFS_CTRL, 32'h001);
        wait_irq();
        `CHK("done irq", 1'b1, irq)
        `CHK("link out", 1'b1, link_out)
        `CHK("bursts", b0 + 2, bursts)
        `CHK("beats", w0 + 8, beats)
        `CHK("last addr", 32'habcd001c, last_addr)
        `CHK("last data", 32'h5a5a011c, last_data)
        wb(1'b0, dma_pkg::OFS_CTRL, 32'h0);
        `CHK("enable off", 1'b0, q[0])
        wb(1'b1, dma_pkg::OFS_STATUS, 32'hf);
    endtask

    task automatic t_chain_link;
        setup(32'h4, 32'h1);
        // byte order reversed as well
        wb(1'b1, dma_pkg::OFS_PARAMS, 32'h0000000f);
        wb(1'b1, dma_pkg::OFS_CTRL, 32'h400);
        `CHK("no read before link", 1'b0, rd_req)
        link_in <= 1'b1;
        @(posedge clk);
        link_in <= 1'b0;
        for (int n = 0; n < 20 && rd_req !== 1'b1; n++) @(posedge clk);
        `CHK("read after link", 1'b1, rd_req)
        wait_irq();
        `CHK("chain beats", w0 + 4, beats)
        `CHK("chain burst", b0 + 1, bursts)
        `CHK("chain swapped data", 32'h0c015a5a, last_data)
        wb(1'b1, dma_pkg::OFS_STATUS, 32'hf);
        wb(1'b1, dma_pkg::OFS_CTRL, 32'h0);
    endtask

    task automatic t_hw_sync;
        setup(32'h4, 32'h1);
        // source side sync line 1: reads wait for requests
        wb(1'b1, dma_pkg::OFS_CTRL, 32'h103);
        repeat (20) @(posedge clk);
        `CHK("no read w/o request", r0, reads)
        peripheral_request <= 1'b1;
        wait_irq();
        `CHK("hw sync beats", w0 + 4, beats)
        peripheral_request <= 1'b0;
        wb(1'b1, dma_pkg::OFS_STATUS, 32'hf);
        wb(1'b1, dma_pkg::OFS_CTRL, 32'h0);
    endtask

    task automatic t_dest_prefetch;
        rd_delay <= 4'h6;
        setup(32'h4, 32'h1);
        // request arrives well before the first read answer
        wb(1'b1, dma_pkg::OFS_CTRL, 32'h203);
        peripheral_request <= 1'b1;
        wait_irq();
        `CHK("zero byte enable", 0, bad_be)
        `CHK("prefetch beats", w0 + 4, beats)
        `CHK("prefetch burst", b0 + 1, bursts)
        peripheral_request <= 1'b0;
        rd_delay <= 4'h1;
        wb(1'b1, dma_pkg::OFS_STATUS, 32'hf);
    endtask

    task automatic t_abort_recover;
        setup(32'h8, 32'h1);
        err_arm <= 1'b1;
        wb(1'b1, dma_pkg::OFS_MASK, 32'h4);
        wb(1'b1, dma_pkg::OFS_CTRL, 32'h001);
        wait_irq();
        err_arm <= 1'b0;
        `CHK("error irq", 1'b1, irq)
        wb(1'b0, dma_pkg::OFS_STATUS, 32'h0);
        `CHK("error flag", 4'h4, q[3:0])
        wb(1'b0, dma_pkg::OFS_CTRL, 32'h0);
        `CHK("self disable", 1'b0, q[0])
        wb(1'b1, dma_pkg::OFS_CTRL, 32'h0);
        wb(1'b1, dma_pkg::OFS_STATUS, 32'h4);
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        setup(32'h8, 32'h0);
        wb(1'b1, dma_pkg::OFS_MASK, 32'h2);
        wb(1'b1, dma_pkg::OFS_CTRL, 32'h001);
        wait_irq();
        wb(1'b0, dma_pkg::OFS_STATUS, 32'h0);
        `CHK("misalign flag", 4'h2, q[3:0])
        `CHK("no data moved", r0, reads)
        wb(1'b1, dma_pkg::OFS_STATUS, 32'h2);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset_values();
        t_sw_burst();
        t_chain_link();
        t_hw_sync();
        t_dest_prefetch();
        t_abort_recover();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
endmodule // test_dma_channel_abort_chain_recovery
